// file: rfcfg_regs.sv
`timescale 1ns/1ps
module rfcfg_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register access
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  input  wire logic [7:0]  reg_addr,       // register address
  input  wire logic [31:0] reg_wdata,      // write data
  output logic [31:0]      reg_rdata,      // read data
  output logic             reg_rvalid,     // read data valid pulse
  output logic             reg_busy,       // access refused while high
  // calibration engine
  input  wire logic [3:0]  dpc_gear,       // live gear from power control
  output logic             cal_start,
  output logic [3:0]       cal_gear,
  input  wire logic        cal_done,
  input  wire logic [9:0]  cal_value,
  // transmitter settings
  output logic [3:0]       card_cw_gain_step,
  output logic [3:0]       card_mod_gain_step,
  output logic [3:0]       reader_mod_gain_step,
  output logic [3:0]       reader_cw_gain_step,
  output logic             force_max_output,
  output logic [1:0]       carrier_amplitude,
  output logic             carrier_ref_to_supply,
  // disturbance filter
  output logic [2:0]       comm_timer_onehot, // zero for reserved code
  input  wire logic        rx_end,            // reception finished pulse
  input  wire logic        rx_error,          // reception had an error
  input  wire logic [7:0]  rx_byte_count,     // bytes without CRC
  output logic             rx_report,         // error reported to host
  output logic             rx_discard,        // error dropped as noise
  // antenna control
  input  wire logic        card_mode,         // low means reader mode
  input  wire logic        active_mod,        // active load modulation
  input  wire logic        tx_active,
  input  wire logic        transmit_envelope,
  output logic             ant_short,
  output logic             ant_mod
);

  // ****************************************************************
  // register storage
  // ****************************************************************
  logic [31:0] txp_reg,   txp_next;    // tx_power_config
  logic [31:0] dc_reg,    dc_next;     // disturbance_control
  logic [31:0] ac_reg,    ac_next;     // antenna_control
  logic [31:0] rdata_reg, rdata_next;
  logic        rv_reg,    rv_next;
  logic        cal_rd_pend;            // calibration read held until its answer is given
  logic        pend_reg,  pend_next;

  rfcfg_cal_if cif ();

  // calibration writes, and reads before any write, start a sequencer run; the host is expected to
  // read first and write back the gain value it got
  assign cif.rd_req  = reg_rd && !reg_busy && (reg_addr == rfcfg_pkg::ADDR_CAL_REF);
  assign cif.wr_req  = reg_wr && !reg_busy && (reg_addr == rfcfg_pkg::ADDR_CAL_REF);
  assign cif.wr_gear = reg_wdata[rfcfg_pkg::CAL_GEAR_LSB +: rfcfg_pkg::CAL_GEAR_W];

  rfcfg_cal_seq u_seq (
    .clk       (clk),
    .rst       (rst),
    .cif       (cif.seq),
    .auto_gear (dpc_gear),
    .cal_start (cal_start),
    .cal_gear  (cal_gear),
    .cal_done  (cal_done),
    .cal_value (cal_value)
  );

  // busy covers both a running calibration and a pending answer
  assign cal_rd_pend = pend_reg;
  assign reg_busy    = cif.busy || cal_rd_pend;

  // ****************************************************************
  // register writes and read answers
  // ****************************************************************
  always_comb begin
    txp_next   = txp_reg;
    dc_next    = dc_reg;
    ac_next    = ac_reg;
    rdata_next = rdata_reg;
    rv_next    = 1'b0;
    pend_next  = pend_reg;
    if (reg_wr && !reg_busy) begin
      // masks keep reserved bits at zero
      unique case (reg_addr)
        rfcfg_pkg::ADDR_TX_POWER: txp_next = reg_wdata & rfcfg_pkg::MASK_TX_POWER;
        rfcfg_pkg::ADDR_DISTURB:  dc_next  = reg_wdata & rfcfg_pkg::MASK_DISTURB;
        rfcfg_pkg::ADDR_ANTENNA:  ac_next  = reg_wdata & rfcfg_pkg::MASK_ANTENNA;
        default: ;                // other addresses ignored
      endcase
    end
    if (reg_rd && !reg_busy) begin
      unique case (reg_addr)
        // answered by sequencer; a write in the same cycle wins, so no answer is owed
        rfcfg_pkg::ADDR_CAL_REF: pend_next  = !reg_wr;
        rfcfg_pkg::ADDR_TX_POWER: begin
          rdata_next = txp_reg;
          rv_next    = 1'b1;
        end
        rfcfg_pkg::ADDR_DISTURB: begin
          rdata_next = dc_reg;
          rv_next    = 1'b1;
        end
        rfcfg_pkg::ADDR_ANTENNA: begin
          rdata_next = ac_reg;
          rv_next    = 1'b1;
        end
        default: begin
          rdata_next = 32'h0000_0000;  // unmapped reads zero
          rv_next    = 1'b1;
        end
      endcase
    end
    if (cif.rd_done) begin
      // gear and gain reference returned together
      rdata_next = {18'h00000, cif.gear, cif.value};
      rv_next    = 1'b1;
      pend_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txp_reg   <= rfcfg_pkg::RST_TX_POWER;
      dc_reg    <= rfcfg_pkg::RST_DISTURB;
      ac_reg    <= rfcfg_pkg::RST_ANTENNA;
      rdata_reg <= 32'h0000_0000;
      rv_reg    <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      txp_reg   <= txp_next;
      dc_reg    <= dc_next;
      ac_reg    <= ac_next;
      rdata_reg <= rdata_next;
      rv_reg    <= rv_next;
      pend_reg  <= pend_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rv_reg;

  // ****************************************************************
  // transmitter settings, straight from the register
  // ****************************************************************
  assign card_cw_gain_step     = txp_reg[rfcfg_pkg::TXP_CARD_CW_LSB +: 4];
  assign card_mod_gain_step    = txp_reg[rfcfg_pkg::TXP_CARD_MOD_LSB +: 4];
  assign reader_mod_gain_step  = txp_reg[rfcfg_pkg::TXP_READER_MOD_LSB +: 4];
  assign reader_cw_gain_step   = txp_reg[rfcfg_pkg::TXP_READER_CW_LSB +: 4];
  assign force_max_output      = txp_reg[rfcfg_pkg::TXP_FORCE_MAX_BIT];
  assign carrier_amplitude     = txp_reg[rfcfg_pkg::TXP_AMPL_LSB +: 2];
  assign carrier_ref_to_supply = txp_reg[rfcfg_pkg::TXP_REF_SUPPLY_BIT];

  // ****************************************************************
  // disturbance filter
  // ****************************************************************
  logic [1:0] timer_sel;
  logic [7:0] noise_thr;
  logic       dist_on, above_no_dist, is_noise;
  logic       rep_reg, rep_next, dis_reg, dis_next;

  assign timer_sel     = dc_reg[rfcfg_pkg::DC_TIMER_LSB +: 2];
  assign noise_thr     = {4'h0, dc_reg[rfcfg_pkg::DC_THRESH_LSB +: 4]};
  assign dist_on       = dc_reg[rfcfg_pkg::DC_ENABLE_BIT];
  assign above_no_dist = dc_reg[rfcfg_pkg::DC_ABOVE_NO_DIST];

  // one-hot timer choice; reserved code 11 selects none
  always_comb begin
    comm_timer_onehot = 3'h0;
    if (timer_sel != 2'b11) begin
      comm_timer_onehot[timer_sel] = 1'b1;
    end
  end

  // byte count arrives without CRC bytes, compared to threshold
  // threshold rules when bit1 is set; else the fixed floor of four
  always_comb begin
    if (above_no_dist) begin
      is_noise = (rx_byte_count < noise_thr);
    end else begin
      is_noise = (rx_byte_count < rfcfg_pkg::NOISE_MIN_BYTES);
    end
    rep_next = rx_end && rx_error && !(dist_on && is_noise);
    dis_next = rx_end && rx_error && dist_on && is_noise;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rep_reg <= 1'b0;
      dis_reg <= 1'b0;
    end else begin
      rep_reg <= rep_next;
      dis_reg <= dis_next;
    end
  end

  assign rx_report  = rep_reg;
  assign rx_discard = dis_reg;

  // ****************************************************************
  // antenna short and modulation outputs
  // ****************************************************************
  logic short_next, mod_next, short_reg, mod_reg;
  logic short_pas, mod_pas;

  // map a select code onto the envelope
  function automatic logic sel_out(input logic [1:0] code, input logic env);
    unique case (code)
      rfcfg_pkg::SEL_LOW:  sel_out = 1'b0;
      rfcfg_pkg::SEL_HIGH: sel_out = 1'b1;
      rfcfg_pkg::SEL_ENV:  sel_out = env;
      default:             sel_out = ~env;
    endcase
  endfunction

  always_comb begin
    short_pas = sel_out(ac_reg[rfcfg_pkg::AC_SHORT_LSB +: 2], transmit_envelope);
    mod_pas   = sel_out(ac_reg[rfcfg_pkg::AC_MOD_LSB +: 2], transmit_envelope);
    if (!card_mode) begin
      // reader mode: logic drives short low, bit4 picks mod source
      short_next = 1'b0;
      mod_next   = ac_reg[rfcfg_pkg::AC_READER_SRC_BIT] ? tx_active
                                                        : transmit_envelope;
    end else if (active_mod && ac_reg[rfcfg_pkg::AC_AUTO_BIT]) begin
      if (ac_reg[rfcfg_pkg::AC_RESET_BIT]) begin
        short_next = 1'b0;                 // back to receive setting
        mod_next   = 1'b0;
      end else begin
        short_next = tx_active;            // hardware switching
        mod_next   = transmit_envelope;
      end
    end else begin
      // passive settings, also reused by active mode without auto
      // inversion is ignored whenever auto switching is enabled
      short_next = short_pas ^ (ac_reg[rfcfg_pkg::AC_INVERT_BIT]
                                && !ac_reg[rfcfg_pkg::AC_AUTO_BIT] && tx_active);
      mod_next   = mod_pas;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      short_reg <= 1'b0;
      mod_reg   <= 1'b0;
    end else begin
      short_reg <= short_next;
      mod_reg   <= mod_next;
    end
  end

  assign ant_short = short_reg;
  assign ant_mod   = mod_reg;

endmodule // rfcfg_regs

// file: rfcfg_pkg.sv
// ****************************************************************
// rf frontend configuration constants
// ****************************************************************
package rfcfg_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CAL_REF     = 8'h26; // calibration reference
  localparam logic [7:0] ADDR_TX_POWER    = 8'h27; // tx_power_config
  localparam logic [7:0] ADDR_DISTURB     = 8'h28; // disturbance_control
  localparam logic [7:0] ADDR_ANTENNA     = 8'h29; // antenna_control

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [31:0] RST_TX_POWER    = 32'h0000_0000;
  localparam logic [31:0] RST_DISTURB     = 32'h0000_0000;
  localparam logic [31:0] RST_ANTENNA     = 32'h0000_0000;
  localparam logic [31:0] MASK_TX_POWER   = 32'h000f_ffff; // bits 19:0
  localparam logic [31:0] MASK_DISTURB    = 32'h0000_03ff; // bits 9:0
  localparam logic [31:0] MASK_ANTENNA    = 32'h0000_00ff; // bits 7:0

  // ****************************************************************
  // calibration reference fields
  // ****************************************************************
  localparam int CAL_GEAR_LSB  = 10;            // gear at 13:10
  localparam int CAL_GEAR_W    = 4;
  localparam int CAL_VALUE_LSB = 0;             // gain reference at 9:0
  localparam int CAL_VALUE_W   = 10;

  // ****************************************************************
  // tx_power_config fields
  // ****************************************************************
  localparam int TXP_CARD_CW_LSB    = 16;
  localparam int TXP_CARD_MOD_LSB   = 12;
  localparam int TXP_READER_MOD_LSB = 8;
  localparam int TXP_READER_CW_LSB  = 4;
  localparam int TXP_GAIN_W         = 4;
  localparam int TXP_FORCE_MAX_BIT  = 3;
  localparam int TXP_AMPL_LSB       = 1;
  localparam int TXP_AMPL_W         = 2;
  localparam int TXP_REF_SUPPLY_BIT = 0;

  // ****************************************************************
  // disturbance_control fields
  // ****************************************************************
  localparam int DC_TIMER_LSB       = 8;
  localparam int DC_TIMER_W         = 2;
  localparam int DC_THRESH_LSB      = 2;
  localparam int DC_THRESH_W        = 4;
  localparam int DC_ABOVE_NO_DIST   = 1;
  localparam int DC_ENABLE_BIT      = 0;
  localparam logic [7:0] NOISE_MIN_BYTES = 8'h04; // fixed noise floor
  localparam int RX_COUNT_W         = 8;

  // ****************************************************************
  // antenna_control fields
  // ****************************************************************
  localparam int AC_INVERT_BIT      = 7;
  localparam int AC_AUTO_BIT        = 6;
  localparam int AC_RESET_BIT       = 5;
  localparam int AC_READER_SRC_BIT  = 4;
  localparam int AC_SHORT_LSB       = 2;
  localparam int AC_MOD_LSB         = 0;

  // output select codes for short/mod outputs
  typedef enum logic [1:0] {
    SEL_LOW      = 2'b00,  // constant low
    SEL_HIGH     = 2'b01,  // constant high
    SEL_ENV      = 2'b10,  // envelope, idle high
    SEL_ENV_INV  = 2'b11   // inverted envelope, idle low
  } rfcfg_sel_t;

endpackage

// file: rfcfg_cal_if.sv
`timescale 1ns/1ps
// ****************************************************************
// register file <-> calibration sequencer
// ****************************************************************
interface rfcfg_cal_if;
  logic       rd_req;     // host read of calibration reference
  logic       wr_req;     // host write of calibration reference
  logic [3:0] wr_gear;    // gear carried by the write
  logic [3:0] gear;       // stored gear
  logic [9:0] value;      // stored gain reference
  logic       busy;       // calibration running
  logic       rd_done;    // read answer ready, one cycle

  modport regs (output rd_req, output wr_req, output wr_gear,
                input gear, input value, input busy, input rd_done);
  modport seq  (input rd_req, input wr_req, input wr_gear,
                output gear, output value, output busy, output rd_done);
endinterface

// file: rfcfg_cal_seq.sv
`timescale 1ns/1ps
// ****************************************************************
// calibration sequencer for the reference register
// ****************************************************************
module rfcfg_cal_seq (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // register file side
  rfcfg_cal_if.seq    cif,
  // calibration engine
  input  wire logic [3:0] auto_gear,   // gear from power control and detuning
  output logic            cal_start,   // one-cycle start pulse
  output logic [3:0]      cal_gear,    // gear used by the run
  input  wire logic       cal_done,    // engine finished
  input  wire logic [9:0] cal_value    // derived gain reference
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,  // waiting for host access
    ST_CAL_WR = 2'b01,  // running after a write
    ST_CAL_RD = 2'b10   // running for a read answer
  } rfcfg_st_t;

  rfcfg_st_t  st_reg,      st_next;
  logic [3:0] gear_reg,    gear_next;
  logic [9:0] value_reg,   value_next;
  logic       written_reg, written_next;  // a write has been seen
  logic       start_reg,   start_next;
  logic       done_reg,    done_next;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next      = st_reg;
    gear_next    = gear_reg;
    value_next   = value_reg;
    written_next = written_reg;
    start_next   = 1'b0;
    done_next    = 1'b0;
    unique case (st_reg)
      ST_IDLE: begin
        if (cif.wr_req) begin
          // written gear taken as given, detuning ignored
          gear_next    = cif.wr_gear;
          written_next = 1'b1;
          start_next   = 1'b1;
          st_next      = ST_CAL_WR;
        end else if (cif.rd_req && !written_reg) begin
          // read without prior write calibrates on the live gear
          gear_next  = auto_gear;
          start_next = 1'b1;
          st_next    = ST_CAL_RD;
        end else if (cif.rd_req) begin
          done_next = 1'b1;  // stored values answer at once
        end
      end
      ST_CAL_WR: begin
        if (cal_done) begin
          value_next = cal_value;  // reference used by detection
          st_next    = ST_IDLE;
        end
      end
      ST_CAL_RD: begin
        if (cal_done) begin
          value_next = cal_value;  // gear and value both returned
          done_next  = 1'b1;
          st_next    = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;  // code 11 is illegal
    endcase
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg      <= ST_IDLE;
      gear_reg    <= 4'h0;
      value_reg   <= 10'h000;
      written_reg <= 1'b0;
      start_reg   <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      st_reg      <= st_next;
      gear_reg    <= gear_next;
      value_reg   <= value_next;
      written_reg <= written_next;
      start_reg   <= start_next;
      done_reg    <= done_next;
    end
  end

  assign cal_start   = start_reg;
  assign cal_gear    = gear_reg;
  assign cif.gear    = gear_reg;
  assign cif.value   = value_reg;
  assign cif.busy    = (st_reg != ST_IDLE);
  assign cif.rd_done = done_reg;

endmodule // rfcfg_cal_seq

// file: rfcfg_regs_assertions.sv
`timescale 1ns/1ps
// ********************
// register block checker
// ********************
module rfcfg_regs_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register access
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic        reg_busy,
  // calibration
  input wire logic        cal_start,
  input wire logic [3:0]  cal_gear,
  input wire logic        cal_done,
  // filter and antenna
  input wire logic [2:0]  comm_timer_onehot,
  input wire logic        rx_end,
  input wire logic        rx_error,
  input wire logic        rx_report,
  input wire logic        rx_discard,
  input wire logic        card_mode,
  input wire logic        ant_short
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_rd_answer; reg_rd && !reg_wr && !reg_busy
    && reg_addr inside {8'h27, 8'h28, 8'h29} |=> reg_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  // while busy nothing is answered except the pending calibration read
  // the pending answer lands in the cycle in which busy falls
  property p_refuse; reg_busy && !cal_done |=> !reg_rvalid || !reg_busy; endproperty
  a_refuse: assert property (p_refuse) else $error("answer while busy");
  property p_cal_wr; reg_wr && !reg_busy && reg_addr == 8'h26
    |=> cal_start && cal_gear == $past(reg_wdata[13:10]); endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("written gear not used");
  property p_busy; cal_start |-> reg_busy; endproperty
  a_busy: assert property (p_busy) else $error("run without busy");
  // a write run frees the bus at once; a read run one cycle later, with its answer
  property p_release; reg_busy && cal_done |=> (!reg_busy)
    or (reg_busy ##1 (!reg_busy && reg_rvalid)); endproperty
  a_release: assert property (p_release) else $error("busy after done");
  property p_timer; reg_wr && !reg_busy && reg_addr == 8'h28 |=> comm_timer_onehot ==
    (($past(reg_wdata[9:8]) == 2'b11) ? 3'b000 : (3'b001 << $past(reg_wdata[9:8])));
  endproperty
  a_timer: assert property (p_timer) else $error("timer select wrong");
  property p_rx_quiet; rx_end && !rx_error |=> !rx_report && !rx_discard; endproperty
  a_rx_quiet: assert property (p_rx_quiet) else $error("clean rx flagged");
  property p_short_rm; !card_mode |=> !ant_short; endproperty
  a_short_rm: assert property (p_short_rm) else $error("short in reader mode");
endmodule // rfcfg_regs_assertions

bind rfcfg_regs rfcfg_regs_assertions i_rfcfg_regs_assertions (.*);

// file: rfcfg_cal_model.sv
`timescale 1ns/1ps
// ********************
// calibration engine stand-in
// ********************
module rfcfg_cal_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // run request and answer
  input  wire logic       cal_start,
  input  wire logic [3:0] cal_gear,
  input  wire logic [3:0] lag,       // answer delay, 1 prompt, 15 slow
  output logic            cal_done,
  output logic [9:0]      cal_value
);
  logic [3:0] cnt_reg;  // cycles left in the run
  logic [3:0] gear_reg; // gear of the run
  // value is valid only with done; it toggles otherwise so a late sample shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 4'h0;
      gear_reg  <= 4'h0;
      cal_done  <= 1'b0;
      cal_value <= 10'h155;
    end else begin
      cal_done  <= 1'b0;
      cal_value <= ~cal_value;
      if (cal_start) begin // run with the gear handed over
        cnt_reg  <= lag;
        gear_reg <= cal_gear;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          cal_done  <= 1'b1;
          cal_value <= {gear_reg, ~gear_reg, 2'b10};
        end
      end
    end
  end
endmodule // rfcfg_cal_model

// file: tb_top.sv
`timescale 1ns/1ps
// ********************
// register block bench
// ********************
module tb_top;
  logic        clk = 1'b0, rst = 1'b1;  // 5 ns clock, async reset
  logic        reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, reg_busy;
  logic [7:0]  reg_addr = 8'h00, rx_byte_count = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, v, last_tx;
  logic [3:0]  dpc_gear = 4'h0, lag = 4'h1, cal_gear, m;
  logic [3:0]  card_cw_gain_step, card_mod_gain_step, reader_mod_gain_step;
  logic [3:0]  reader_cw_gain_step;
  logic        cal_start, cal_done, force_max_output, carrier_ref_to_supply;
  logic        rx_report, rx_discard, ant_short, ant_mod;
  logic [9:0]  cal_value;
  logic [1:0]  carrier_amplitude;
  logic [2:0]  comm_timer_onehot;
  logic        rx_end = 1'b0, rx_error = 1'b0, card_mode = 1'b0, active_mod = 1'b0;
  logic        tx_active = 1'b0, transmit_envelope = 1'b0;
  logic [31:0] seed = 32'hc5c5;     // fixed so runs repeat
  logic [31:0] msk [3] = '{rfcfg_pkg::MASK_TX_POWER, rfcfg_pkg::MASK_DISTURB,
                           rfcfg_pkg::MASK_ANTENNA};
  int          miscompares = 0, total_checks = 0;

  always #2.5 clk = ~clk;
  rfcfg_regs i_rfcfg_regs (.*);
  rfcfg_cal_model i_rfcfg_cal_model (.*);

  // 00 low, 01 high, 10 envelope, 11 inverted envelope
  function automatic logic sel(input logic [1:0] s, input logic e);
    return s[1] ? (e ^ s[0]) : s[0];
  endfunction
  // {short, mod} from register and {card, active, tx, envelope}
  function automatic logic [1:0] ant(input logic [7:0] a, input logic [3:0] i);
    if (!i[3]) return {1'b0, a[4] ? i[1] : i[0]};
    if (i[2] && a[6]) return a[5] ? 2'b00 : i[1:0];
    return {sel(a[3:2], i[0]) ^ (a[7] & ~a[6] & i[1]), sel(a[1:0], i[0])};
  endfunction
  // {report, discard} for an erroneous reception
  function automatic logic [1:0] cls(input logic [31:0] c, input logic [7:0] n);
    logic noise;
    noise = c[1] ? (n < {4'h0, c[5:2]}) : (n < 8'h04);
    return (c[0] && noise) ? 2'b01 : 2'b10;
  endfunction
  // reference word after a run on gear g
  function automatic logic [31:0] calw(input logic [3:0] g);
    return {18'h0, g, g, ~g, 2'b10};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = w;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  // one-cycle read strobe; calibration reads answer late, so wait bounded
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    for (int n = 0; n < 40 && reg_rvalid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check("read answer", {31'h0, reg_rvalid}, 32'h1);
    r = reg_rdata;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // the run needs under 2000 cycles; this leaves a wide margin
  initial begin
    #100000;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    for (int a = 8'h27; a < 8'h2b; a++) begin // 0x2a is unmapped
      rd(8'(a), v);
      check("reset value", v, 32'h0);
    end
    for (int i = 0; i < 24; i++) begin // random fill, every timer code
      d = $random(seed);
      d[9:8] = 2'(i / 3);
      wr(8'h27 + 8'(i % 3), d);
      if (i % 3 == 0) begin
        last_tx = d & msk[0];
        check("tx fields", {12'h0, card_cw_gain_step, card_mod_gain_step,
          reader_mod_gain_step, reader_cw_gain_step, force_max_output,
          carrier_amplitude, carrier_ref_to_supply}, last_tx);
      end
      if (i % 3 == 1) check("timer", {29'h0, comm_timer_onehot},
        (d[9:8] == 2'b11) ? 32'h0 : (32'h1 << d[9:8]));
      rd(8'h27 + 8'(i % 3), v);
      check("readback", v, d & msk[i % 3]);
    end
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 32'h0000_0187 : $random(seed); // suggested setting
      wr(8'h28, d);
      @(posedge clk);
      #1 rx_end = 1'b1;
      rx_error = (i % 5 != 4);
      rx_byte_count = (i % 4 == 1) ? {4'h0, d[5:2]} : 8'($random(seed) & 31);
      @(posedge clk);
      #1 rx_end = 1'b0;
      check("rx class", {30'h0, rx_report, rx_discard},
        rx_error ? cls(d, rx_byte_count) : 2'b00);
    end
    for (int i = 0; i < 48; i++) begin
      d = $random(seed);
      wr(8'h29, d);
      m = 4'($random(seed));
      {card_mode, active_mod, tx_active, transmit_envelope} = m;
      @(posedge clk);
      #1;
      check("antenna", {30'h0, ant_short, ant_mod}, ant(d[7:0], m));
    end
    lag = 4'h3;
    dpc_gear = 4'h9;
    rd(8'h26, v);
    check("cal read", v, calw(4'h9));
    lag = 4'hf;
    wr(8'h26, {18'h0, 4'h3, v[9:0]}); // own gear, value read back
    wr(8'h27, 32'h000f_ffff); // lands while busy, must be dropped
    for (int n = 0; n < 40 && reg_busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    dpc_gear = 4'he;
    rd(8'h27, v);
    check("busy refusal", v, last_tx);
    rd(8'h26, v);
    check("cal write", v, calw(4'h3));
    test_done();
  end
endmodule // tb_top
